// ---- src/wdw_watchdog.sv ----
// windowed watchdog timer with its register port and change protection
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module wdw_watchdog #(
    parameter logic [7:0] UNLOCK_KEY_P = wdw_pkg::UNLOCK_KEY,
    parameter logic [2:0] UNLOCK_WIN_P = wdw_pkg::UNLOCK_WINDOW
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic [wdw_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [wdw_pkg::DATA_W-1:0] regWrData,
    input  wire logic                       regWrStb,
    input  wire logic                       regRdStb,
    output logic      [wdw_pkg::DATA_W-1:0] regRdData,
    input  wire logic [wdw_pkg::DATA_W-1:0] watchdogFuseConfig,
    input  wire logic                       watchdogDomainClock,
    input  wire logic                       watchdogRestartInstr,
    input  wire logic                       debugHalt,
    output logic                            systemReset
);
    import wdw_pkg::*;

    logic [DATA_W-1:0]  controlRegA_ff;
    logic               lock_ff;
    logic [2:0]         unlockCnt_ff;
    logic               unlocked;
    logic               ctrlWrite;
    logic               statusWrite;
    logic               unlockWrite;
    logic [FIELD_W-1:0] actPeriod_ff;
    logic [FIELD_W-1:0] actWindow_ff;
    wdw_sync_e          cfgSync_ff;
    wdw_sync_e          rstSync_ff;
    logic               clkMeta_ff;
    logic               clkSync_ff;
    logic               clkPrev_ff;
    logic               tick;
    logic [CNT_W-1:0]   cnt_ff;
    logic               windowArmed_ff;
    logic [CNT_W-1:0]   openLen;
    logic [CNT_W-1:0]   closedLen;
    logic               enabled;
    logic               windowMode;
    logic               restartApply;
    logic [CNT_W-1:0]   nxt_cnt;
    logic [DATA_W-1:0]  nxt_rdData;

    // code to cycle count; reserved codes clamp to the longest period
    function automatic logic [CNT_W-1:0] periodCycles(
        input logic [FIELD_W-1:0] code
    );
        logic [FIELD_W-1:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        periodCycles = BASE_CYCLES << (c - 4'h1);
    endfunction

    // protected register port
    assign unlocked    = (unlockCnt_ff != 3'h0);
    assign ctrlWrite   = regWrStb && (regAddr == OFF_CTRL_A);
    assign statusWrite = regWrStb && (regAddr == OFF_STATUS);
    assign unlockWrite = regWrStb && (regAddr == OFF_UNLOCK);

    // the unlock window is counted in core cycles, one per instruction
    always_ff @(posedge core_clk) begin
        if (rst) begin
            unlockCnt_ff <= 3'h0;
        end else if (unlockWrite && regWrData == UNLOCK_KEY_P) begin
            unlockCnt_ff <= UNLOCK_WIN_P;
        end else if ((ctrlWrite || statusWrite) && unlocked) begin
            unlockCnt_ff <= 3'h0;
        end else if (unlocked) begin
            unlockCnt_ff <= unlockCnt_ff - 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            controlRegA_ff <= watchdogFuseConfig;
        end else if (ctrlWrite && unlocked && !lock_ff) begin
            controlRegA_ff <= regWrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_ff <= |watchdogFuseConfig[PER_LSB +: FIELD_W];
        end else if (statusWrite && unlocked) begin
            if (regWrData[LOCK_BIT]) begin
                lock_ff <= 1'b1;
            end else if (debugHalt) begin
                lock_ff <= 1'b0;
            end
        end
    end

    // oscillator pin: two flops, then an edge makes the watchdog tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clkMeta_ff <= 1'b0;
            clkSync_ff <= 1'b0;
            clkPrev_ff <= 1'b0;
        end else begin
            clkMeta_ff <= watchdogDomainClock;
            clkSync_ff <= clkMeta_ff;
            clkPrev_ff <= clkSync_ff;
        end
    end
    assign tick = clkSync_ff && !clkPrev_ff;

    // configuration transfer takes two watchdog ticks
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfgSync_ff <= WDW_SYNC_IDLE;
        end else if (ctrlWrite && unlocked && !lock_ff) begin
            cfgSync_ff <= WDW_SYNC_WAIT1;
        end else if (tick) begin
            case (cfgSync_ff)
                WDW_SYNC_WAIT1: cfgSync_ff <= WDW_SYNC_WAIT2;
                WDW_SYNC_WAIT2: cfgSync_ff <= WDW_SYNC_IDLE;
                default:        cfgSync_ff <= WDW_SYNC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            actPeriod_ff <= watchdogFuseConfig[PER_LSB +: FIELD_W];
            actWindow_ff <= watchdogFuseConfig[WIN_LSB +: FIELD_W];
        end else if (tick && cfgSync_ff == WDW_SYNC_WAIT2) begin
            actPeriod_ff <= controlRegA_ff[PER_LSB +: FIELD_W];
            actWindow_ff <= controlRegA_ff[WIN_LSB +: FIELD_W];
        end
    end

    // restart crossing: applied on the second tick, so 1 to 2 watchdog clock periods late
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rstSync_ff <= WDW_SYNC_IDLE;
        end else if (watchdogRestartInstr
                     && rstSync_ff == WDW_SYNC_IDLE) begin
            rstSync_ff <= WDW_SYNC_WAIT1;
        end else if (tick) begin
            case (rstSync_ff)
                WDW_SYNC_WAIT1: rstSync_ff <= WDW_SYNC_WAIT2;
                WDW_SYNC_WAIT2: rstSync_ff <= WDW_SYNC_IDLE;
                default:        rstSync_ff <= WDW_SYNC_IDLE;
            endcase
        end
    end
    assign restartApply = tick && rstSync_ff == WDW_SYNC_WAIT2;

    // time-out engine
    assign openLen    = periodCycles(actPeriod_ff);
    assign closedLen  = periodCycles(actWindow_ff);
    assign enabled    = (actPeriod_ff != CODE_OFF);
    assign windowMode = (actWindow_ff != CODE_OFF) && windowArmed_ff;
    assign nxt_cnt    = cnt_ff + 15'h0001;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (debugHalt || !enabled) begin
            cnt_ff <= '0;
        end else if (restartApply) begin
            cnt_ff <= '0;
        end else if (tick) begin
            cnt_ff <= nxt_cnt;
        end
    end

    // window mode is armed by a restart and disarmed by halt or reconfig
    always_ff @(posedge core_clk) begin
        if (rst) begin
            windowArmed_ff <= 1'b0;
        end else if (debugHalt || !enabled) begin
            windowArmed_ff <= 1'b0;
        end else if (tick && cfgSync_ff == WDW_SYNC_WAIT2) begin
            windowArmed_ff <= 1'b0;
        end else if (restartApply) begin
            windowArmed_ff <= (actWindow_ff != CODE_OFF);
        end
    end

    // reset stays asserted until the system reset comes back to us
    always_ff @(posedge core_clk) begin
        if (rst) begin
            systemReset <= 1'b0;
        end else if (enabled && !debugHalt) begin
            if (restartApply && windowMode && cnt_ff < closedLen) begin
                systemReset <= 1'b1;
            end else if (tick && !restartApply && windowMode
                         && nxt_cnt >= closedLen + openLen) begin
                systemReset <= 1'b1;
            end else if (tick && !restartApply && !windowMode
                         && nxt_cnt >= openLen) begin
                systemReset <= 1'b1;
            end
        end
    end

    // read port: data stand one cycle after the strobe
    always_comb begin
        nxt_rdData = '0;
        case (regAddr)
            OFF_CTRL_A: nxt_rdData = controlRegA_ff;
            OFF_STATUS: begin
                nxt_rdData[LOCK_BIT] = lock_ff;
                nxt_rdData[BUSY_BIT] = (cfgSync_ff != WDW_SYNC_IDLE);
            end
            default:    nxt_rdData = '0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regRdData <= '0;
        end else if (regRdStb) begin
            regRdData <= nxt_rdData;
        end else begin
            regRdData <= '0;
        end
    end
endmodule

// ---- src/wdw_pkg.sv ----
// constants shared by the windowed watchdog block
package wdw_pkg;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned DATA_W        = 8;
    localparam logic [3:0]  OFF_CTRL_A    = 4'h0;
    localparam logic [3:0]  OFF_STATUS    = 4'h1;
    localparam logic [3:0]  OFF_UNLOCK    = 4'h2;
    localparam int unsigned PER_LSB       = 0;
    localparam int unsigned WIN_LSB       = 4;
    localparam int unsigned FIELD_W       = 4;
    localparam int unsigned LOCK_BIT      = 7;
    localparam int unsigned BUSY_BIT      = 0;
    localparam logic [3:0]  CODE_OFF      = 4'h0;
    localparam logic [3:0]  CODE_MAX      = 4'hb;
    localparam int unsigned CNT_W         = 15;
    localparam logic [14:0] BASE_CYCLES   = 15'h0008;
    localparam logic [7:0]  UNLOCK_KEY    = 8'ha5;
    localparam logic [2:0]  UNLOCK_WINDOW = 3'h4;
    localparam int unsigned SYNC_TICKS    = 2;
    localparam int unsigned WDT_CLK_HZ    = 1024;
    localparam int unsigned CORE_CLK_MHZ  = 250;
    typedef enum logic [1:0] {
        WDW_SYNC_IDLE  = 2'b00,
        WDW_SYNC_WAIT1 = 2'b01,
        WDW_SYNC_WAIT2 = 2'b10
    } wdw_sync_e;
endpackage

// ---- testbench/wdw_watchdog_checker.sv ----
// port-level assertions for the windowed watchdog
`timescale 1ns/1ns
module wdw_watchdog_checker (
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic [wdw_pkg::ADDR_W-1:0] regAddr,
    input wire logic [wdw_pkg::DATA_W-1:0] regWrData,
    input wire logic                       regWrStb,
    input wire logic                       regRdStb,
    input wire logic [wdw_pkg::DATA_W-1:0] regRdData,
    input wire logic [wdw_pkg::DATA_W-1:0] watchdogFuseConfig,
    input wire logic                       watchdogDomainClock,
    input wire logic                       watchdogRestartInstr,
    input wire logic                       debugHalt,
    input wire logic                       systemReset
);
    import wdw_pkg::*;
    logic [3:0] sinceTick_ff;
    logic       oscSeen_ff;
    // a reset may only follow a recent oscillator edge, never the core clock
    always_ff @(posedge core_clk) begin
        oscSeen_ff <= watchdogDomainClock;
        if (rst || (watchdogDomainClock && !oscSeen_ff)) begin
            sinceTick_ff <= 4'h0;
        end else if (sinceTick_ff != 4'hf) begin
            sinceTick_ff <= sinceTick_ff + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_bootRead;
        $fell(rst) ##1 (regRdStb && regAddr == OFF_CTRL_A);
    endsequence
    property p_rdIdle; !regRdStb |=> regRdData == 8'h00; endproperty
    property p_unmapped;
        regRdStb && regAddr > OFF_UNLOCK |=> regRdData == 8'h00;
    endproperty
    property p_statusRsvd;
        regRdStb && regAddr == OFF_STATUS |=> regRdData[6:1] == 6'h00;
    endproperty
    property p_bootCtrl;
        s_bootRead |=> regRdData == watchdogFuseConfig;
    endproperty
    property p_rstHold; systemReset |=> systemReset; endproperty
    property p_rstClean; $fell(rst) |-> !systemReset; endproperty
    property p_tickCause;
        $rose(systemReset) |-> sinceTick_ff <= 4'h8;
    endproperty
    property p_debugStops; debugHalt [*8] |-> !$rose(systemReset); endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data not idle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_statusRsvd: assert property (p_statusRsvd)
        else $error("status spare bits set");
    a_bootCtrl: assert property (p_bootCtrl)
        else $error("control not loaded from fuse");
    a_rstHold: assert property (p_rstHold)
        else $error("system reset dropped");
    a_rstClean: assert property (p_rstClean)
        else $error("system reset after release");
    a_tickCause: assert property (p_tickCause)
        else $error("reset without watchdog tick");
    a_debugStops: assert property (p_debugStops)
        else $error("reset while halted");
endmodule
bind wdw_watchdog wdw_watchdog_checker wdw_watchdog_checker_i (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .watchdogFuseConfig(watchdogFuseConfig),
    .watchdogDomainClock(watchdogDomainClock),
    .watchdogRestartInstr(watchdogRestartInstr),
    .debugHalt(debugHalt), .systemReset(systemReset));

// ---- testbench/wdw_cpu_model.sv ----
// far side: cpu restart issue and the free-running watchdog oscillator
`timescale 1ns/1ns
module wdw_cpu_model #(
    parameter int HALF_NS = 21
) (
    input  wire logic core_clk,
    input  wire logic doRestart,
    output logic      watchdogRestartInstr = 1'b0,
    output logic      watchdogDomainClock = 1'b0
);
    // sped up so the run stays short; phase drifts against the core clock
    always #(HALF_NS) watchdogDomainClock = ~watchdogDomainClock;
    always @(posedge core_clk) watchdogRestartInstr <= doRestart;
endmodule

// ---- testbench/test_windowed_watchdog_timer.sv ----
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
module test_windowed_watchdog_timer;
    import wdw_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       regWrStb = 1'b0;
    logic       regRdStb = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] fuse = 8'h02;
    logic       debugHalt = 1'b0;
    logic       doRestart = 1'b0;
    logic [7:0] regRdData;
    logic       systemReset;
    logic       restartInstr;
    logic       oscClk;
    int         nFail = 0;
    int         checkCount = 0;
    always #2 core_clk = ~core_clk;
    wdw_cpu_model wdw_cpu_model_i (.core_clk(core_clk), .doRestart(doRestart),
        .watchdogRestartInstr(restartInstr), .watchdogDomainClock(oscClk));
    wdw_watchdog wdw_watchdog_i (.core_clk(core_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData),
        .watchdogFuseConfig(fuse), .watchdogDomainClock(oscClk),
        .watchdogRestartInstr(restartInstr), .debugHalt(debugHalt),
        .systemReset(systemReset));
    task automatic final_report();
        if (nFail == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        checkCount++;
        if (g !== e) begin
            nFail++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrStb <= 1'b0;
    endtask
    // key and protected write land two cycles apart, inside the unlock span
    task automatic wrKey(input logic [3:0] a, input logic [7:0] d);
        wr(OFF_UNLOCK, UNLOCK_KEY);
        wr(a, d);
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, regRdData);
    endtask
    task automatic rstChk(input logic e);
        #1 chk("systemReset", {7'h00, e}, {7'h00, systemReset});
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge oscClk);
        @(posedge core_clk);
    endtask
    task automatic restart();
        @(posedge core_clk);
        doRestart <= 1'b1;
        @(posedge core_clk);
        doRestart <= 1'b0;
    endtask
    task automatic resetDut(input logic [7:0] f);
        @(posedge core_clk);
        fuse <= f;
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    task automatic t_lock();
        resetDut(8'h02);
        rdChk(OFF_CTRL_A, 8'h02);
        rdChk(OFF_STATUS, 8'h80);
        wrKey(OFF_CTRL_A, 8'h05);
        rdChk(OFF_CTRL_A, 8'h02);
        wrKey(OFF_STATUS, 8'h00);
        rdChk(OFF_STATUS, 8'h80);
        @(posedge core_clk);
        debugHalt <= 1'b1;
        wrKey(OFF_STATUS, 8'h00);
        rdChk(OFF_STATUS, 8'h00);
        @(posedge core_clk);
        debugHalt <= 1'b0;
        wr(OFF_CTRL_A, 8'h03);
        rdChk(OFF_CTRL_A, 8'h02);
        wrKey(OFF_CTRL_A, 8'h03);
        rdChk(OFF_STATUS, 8'h01);
        rdChk(OFF_CTRL_A, 8'h03);
        // no further control write until the busy flag has dropped
        ticks(3);
        rdChk(OFF_STATUS, 8'h00);
        rdChk(4'h9, 8'h00);
        wrKey(OFF_STATUS, 8'h80);
        wrKey(OFF_CTRL_A, 8'h07);
        rdChk(OFF_CTRL_A, 8'h03);
    endtask
    task automatic t_normal();
        resetDut(8'h01);
        debugHalt <= 1'b1;
        ticks(20);
        rstChk(1'b0);
        @(posedge core_clk);
        debugHalt <= 1'b0;
        restart();
        ticks(7);
        rstChk(1'b0);
        restart();
        ticks(7);
        rstChk(1'b0);
        ticks(6);
        rstChk(1'b1);
    endtask
    task automatic t_window();
        resetDut(8'h11);
        restart();
        ticks(6);
        rstChk(1'b0);
        restart();
        ticks(4);
        rstChk(1'b1);
        resetDut(8'h11);
        restart();
        ticks(12);
        rstChk(1'b0);
        restart();
        ticks(8);
        rstChk(1'b0);
        ticks(14);
        rstChk(1'b1);
    endtask
    initial begin
        t_lock();
        t_normal();
        t_window();
        final_report();
    end
    initial begin
        #100000;
        nFail++;
        final_report();
    end
endmodule
